// *** rtl/bpmon_cmp.sv ***
`timescale 1ns/100ps
`default_nettype none
module bpmon_cmp (
  bpmon_cmp_if.cmp c
);
  import bpmon_pkg::*;
  wire fetch_ok;
  wire dir_ok;
  wire data_ok;
  wire addr_eq;
  // instruction fetch or data access, and read or write qualification
  assign fetch_ok = (c.inst == c.bus_inst);
  assign dir_ok   = !c.rwe || (c.rw == c.bus_rd);
  assign c.qual   = c.en && c.bus_valid && fetch_ok && dir_ok;
  // a set mask bit drops that data bit from the compare
  assign data_ok  = !c.use_data ||
                    (((c.bus_data ^ c.ref_data) & ~c.mask) == '0);
  assign addr_eq  = (c.bus_addr == c.ref_addr);
  assign c.hit    = c.qual && addr_eq && data_ok;
  assign c.ge     = (c.bus_addr >= c.ref_addr);
  assign c.le     = (c.bus_addr <= c.ref_addr);
endmodule : bpmon_cmp
`default_nettype wire

// *** rtl/bpmon_cmp_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface bpmon_cmp_if;
  import bpmon_pkg::*;
  logic              en;
  logic              inst;
  logic              rwe;
  logic              rw;
  logic              use_data;
  logic [ADDR_W-1:0] ref_addr;
  logic [DATA_W-1:0] ref_data;
  logic [DATA_W-1:0] mask;
  logic              bus_valid;
  logic              bus_rd;
  logic              bus_inst;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_data;
  logic              qual;
  logic              hit;
  logic              ge;
  logic              le;
  modport ctl (output en, inst, rwe, rw, use_data, ref_addr, ref_data,
               mask, bus_valid, bus_rd, bus_inst, bus_addr, bus_data,
               input qual, hit, ge, le);
  modport cmp (input en, inst, rwe, rw, use_data, ref_addr, ref_data,
               mask, bus_valid, bus_rd, bus_inst, bus_addr, bus_data,
               output qual, hit, ge, le);
endinterface : bpmon_cmp_if
`default_nettype wire

// *** rtl/bpmon_pkg.sv ***
package bpmon_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int PADDR_W = 12;
  localparam int NCMP = 3;
  // register byte addresses
  localparam logic [11:0] OFS_CTRL  = 12'h000;
  localparam logic [11:0] OFS_SEQ   = 12'h004;
  localparam logic [11:0] OFS_STAT  = 12'h008;
  localparam logic [11:0] OFS_CCTL  = 12'h00C;
  localparam logic [11:0] OFS_CADR  = 12'h018;
  localparam logic [11:0] OFS_ADATA = 12'h024;
  localparam logic [11:0] OFS_AMASK = 12'h028;
  localparam logic [11:0] OFS_STEP  = 12'h004;
  // monitor_control_one fields
  localparam int CTL_ARM  = 7;
  localparam int CTL_FORCE_TRIGGER = 6;
  localparam int CTL_HALT = 4;
  localparam int CTL_BRK  = 3;
  localparam int CTL_EEV  = 1;
  // sequencer configuration fields
  localparam int SEQ_M1 = 0;
  localparam int SEQ_M2 = 4;
  localparam int SEQ_MD = 8;
  // status fields
  localparam int ST_STATE = 0;
  localparam int ST_EEVF  = 4;
  localparam int ST_TRIGF = 6;
  localparam int ST_HITF  = 8;
  // comparator control fields
  localparam int CC_EN   = 0;
  localparam int CC_INST = 1;
  localparam int CC_RWE  = 2;
  localparam int CC_RW   = 3;
  localparam logic [3:0]  CCTL_RST = 4'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    BPMON_SIMPLE, BPMON_INSIDE, BPMON_OUTSIDE, BPMON_RSVD
  } bpmon_mode_t;
endpackage : bpmon_pkg

// *** rtl/bpmon_top.sv ***
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - three comparators A, B and D watch the processor bus
// - comparator A checks full address and the 32-bit data bus
// - comparator A data mask removes masked bits from the data check
// - comparators B and D check the address only
// - each comparator watches fetch addresses or data access addresses
// - each comparator can qualify on read or on write cycles
// - simple mode matches on equal address and data
// - inside range matches when min <= address <= max
// - outside range matches when address < min or address > max
// - one match or a configured series of matches requests a breakpoint
// - sequencer steps on matches, trigger writes or enabled external events
// - breakpoint requests halted debug state or soft trap, as configured
// - controller halt command is served and leaves the unit armed
// - only falling edges of the external event input are events
// - an enable field in control one gates the external event
// - external input is synchronised, acting three cycles after the edge
// - in stop mode the synchroniser holds and events are ignored
// - the unit works in every functional mode
// - while armed only arm and trigger bits accept writes
// - trigger bit is always writable and reads as zero
// - hardware disarm beats a simultaneous software write
module bpmon_top (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [bpmon_pkg::PADDR_W-1:0] paddr,
  input  wire logic [bpmon_pkg::DATA_W-1:0]  pwdata,
  output var  logic [bpmon_pkg::DATA_W-1:0]  prdata_ff,
  output var  logic                          pready_ff,
  output var  logic                          pslverr_ff,
  input  wire logic                          bus_valid,
  input  wire logic                          bus_rd,
  input  wire logic                          bus_inst,
  input  wire logic [bpmon_pkg::ADDR_W-1:0]  bus_addr,
  input  wire logic [bpmon_pkg::DATA_W-1:0]  bus_data,
  input  wire logic                          halt_cmd,
  input  wire logic                          stop_mode,
  input  wire logic                          ext_event_input,
  output var  logic                          halt_req_ff,
  output var  logic                          trap_req_ff,
  output var  logic                          armed_ff
);
  import bpmon_pkg::*;

  typedef enum logic [1:0] {SQ_IDLE, SQ_ONE, SQ_TWO} bpmon_seq_t;

  function automatic logic any_in(input logic [2:0] h,
                                  input logic [2:0] m);
    any_in = |(h & m);
  endfunction : any_in

  bpmon_seq_t        state_ff;
  bpmon_seq_t        nxt_state;
  logic              nxt_armed;
  logic              halt_sel_ff;
  logic              brk_en_ff;
  logic              ext_en_ff;
  logic [2:0]        mask1_ff;
  logic [2:0]        mask2_ff;
  bpmon_mode_t       mode_ff;
  logic [3:0]        cctl_ff [NCMP];
  logic [ADDR_W-1:0] cadr_ff [NCMP];
  logic [DATA_W-1:0] adata_ff;
  logic [DATA_W-1:0] amask_ff;
  logic              trigf_ff;
  logic              eevf_ff;
  logic [2:0]        hitf_ff;
  logic [2:0]        ext_sync_ff;
  logic              ext_lvl_ff;

  // apb decode
  wire       setup_rd;
  wire       acc;
  wire       wr;
  wire       ctl_wr;
  wire       cfg_wr;
  wire [3:0] sel_cctl;
  wire [3:0] sel_cadr;
  wire       sel_seq;
  wire       sel_adata;
  wire       sel_amask;
  wire       mapped;

  assign acc       = psel && penable && pready_ff;
  assign setup_rd  = psel && !penable && !pwrite;
  assign wr        = acc && pwrite;
  assign ctl_wr    = wr && (paddr == OFS_CTRL);
  assign cfg_wr    = wr && !armed_ff;
  assign sel_seq   = (paddr == OFS_SEQ);
  assign sel_adata = (paddr == OFS_ADATA);
  assign sel_amask = (paddr == OFS_AMASK);
  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++) begin : g_sel
      assign sel_cctl[gi] = (paddr == OFS_CCTL + 12'(gi) * OFS_STEP);
      assign sel_cadr[gi] = (paddr == OFS_CADR + 12'(gi) * OFS_STEP);
    end
  endgenerate
  assign sel_cctl[3] = 1'b0;
  assign sel_cadr[3] = 1'b0;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || sel_seq
                  || (|sel_cctl) || (|sel_cadr) || sel_adata || sel_amask;

  // comparators
  bpmon_cmp_if cif [NCMP] ();
  generate
    for (gi = 0; gi < NCMP; gi++) begin : g_cmp
      assign cif[gi].en        = cctl_ff[gi][CC_EN];
      assign cif[gi].inst      = cctl_ff[gi][CC_INST];
      assign cif[gi].rwe       = cctl_ff[gi][CC_RWE];
      assign cif[gi].rw        = cctl_ff[gi][CC_RW];
      assign cif[gi].use_data  = (gi == 0);
      assign cif[gi].ref_addr  = cadr_ff[gi];
      assign cif[gi].ref_data  = adata_ff;
      assign cif[gi].mask      = amask_ff;
      assign cif[gi].bus_valid = bus_valid;
      assign cif[gi].bus_rd    = bus_rd;
      assign cif[gi].bus_inst  = bus_inst;
      assign cif[gi].bus_addr  = bus_addr;
      assign cif[gi].bus_data  = bus_data;
      bpmon_cmp u_cmp (.c(cif[gi]));
    end
  endgenerate

  // A holds the lower bound, B the upper bound, qualified by A's setup
  wire       in_rng;
  wire       out_rng;
  wire [2:0] hits;
  assign in_rng  = cif[0].qual && cif[0].ge && cif[1].le;
  assign out_rng = cif[0].qual && (!cif[0].ge || !cif[1].le);
  assign hits[0] = (mode_ff == BPMON_INSIDE)  ? in_rng :
                   (mode_ff == BPMON_OUTSIDE) ? out_rng :
                   cif[0].hit;
  assign hits[1] = cif[1].hit;
  assign hits[2] = cif[2].hit;

  // external event: three stages, a fall counts when stages two and
  // three agree low after a high level; frozen in stop mode
  wire ext_fall;
  wire ext_adv;
  assign ext_fall = !stop_mode && ext_lvl_ff && !ext_sync_ff[1]
                    && !ext_sync_ff[2];
  assign ext_adv  = ext_fall && ext_en_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_ff <= 3'h7;
      ext_lvl_ff  <= 1'b1;
    end else if (!stop_mode) begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_event_input};
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_lvl_ff <= ext_sync_ff[2];
      end
    end
  end

  // sequencer
  wire force_trigger_wr;
  wire arm_wr;
  wire adv1;
  wire adv2;
  wire fire;
  assign force_trigger_wr = ctl_wr && pwdata[CTL_FORCE_TRIGGER];
  assign arm_wr  = ctl_wr && pwdata[CTL_ARM];
  assign adv1    = any_in(hits, mask1_ff) || ext_adv;
  assign adv2    = any_in(hits, mask2_ff) || ext_adv;
  assign fire    = armed_ff && (force_trigger_wr || (state_ff == SQ_ONE && adv1
                   && mask2_ff == 3'h0) || (state_ff == SQ_TWO && adv2));

  always_comb begin
    nxt_state = state_ff;
    nxt_armed = armed_ff;
    if (ctl_wr) begin
      nxt_armed = pwdata[CTL_ARM];
    end
    case (state_ff)
      SQ_IDLE: begin
        if (arm_wr) begin
          nxt_state = SQ_ONE;
        end
      end
      SQ_ONE: begin
        if (adv1) begin
          nxt_state = SQ_TWO;
        end
      end
      SQ_TWO: begin
        nxt_state = SQ_TWO;
      end
      default: begin
        nxt_state = SQ_IDLE;
      end
    endcase
    if (armed_ff && !nxt_armed) begin
      nxt_state = SQ_IDLE;
    end
    if (fire) begin
      nxt_armed = 1'b0;
      nxt_state = SQ_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SQ_IDLE;
      armed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      armed_ff <= nxt_armed;
    end
  end

  // breakpoint and halt requests; a halt command leaves arm untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_req_ff <= 1'b0;
      trap_req_ff <= 1'b0;
    end else begin
      halt_req_ff <= (fire && brk_en_ff && halt_sel_ff) || halt_cmd;
      trap_req_ff <= fire && brk_en_ff && !halt_sel_ff;
    end
  end

  // sticky flags, cleared on arming; set only while armed, so an event in the arming cycle is dropped
  wire clr_flags;
  assign clr_flags = arm_wr && !armed_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigf_ff <= 1'b0;
      eevf_ff  <= 1'b0;
      hitf_ff  <= 3'h0;
    end else begin
      trigf_ff <= (trigf_ff && !clr_flags) || (armed_ff && force_trigger_wr);
      eevf_ff  <= (eevf_ff && !clr_flags) || (armed_ff && ext_adv);
      hitf_ff  <= (hitf_ff & {3{!clr_flags}}) | (hits & {3{armed_ff}});
    end
  end

  // configuration, locked while armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_sel_ff <= 1'b0;
      brk_en_ff   <= 1'b0;
      ext_en_ff   <= 1'b0;
      mask1_ff    <= 3'h0;
      mask2_ff    <= 3'h0;
      mode_ff     <= BPMON_SIMPLE;
      adata_ff    <= WORD_RST;
      amask_ff    <= WORD_RST;
    end else if (cfg_wr) begin
      if (paddr == OFS_CTRL) begin
        halt_sel_ff <= pwdata[CTL_HALT];
        brk_en_ff   <= pwdata[CTL_BRK];
        ext_en_ff   <= pwdata[CTL_EEV];
      end
      if (sel_seq) begin
        mask1_ff <= pwdata[SEQ_M1 +: 3];
        mask2_ff <= pwdata[SEQ_M2 +: 3];
        mode_ff  <= bpmon_mode_t'(pwdata[SEQ_MD +: 2]);
      end
      if (sel_adata) begin
        adata_ff <= pwdata;
      end
      if (sel_amask) begin
        amask_ff <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCMP; i++) begin
        cctl_ff[i] <= CCTL_RST;
        cadr_ff[i] <= '0;
      end
    end else if (cfg_wr) begin
      for (int i = 0; i < NCMP; i++) begin
        if (sel_cctl[i]) begin
          cctl_ff[i] <= pwdata[3:0];
        end
        if (sel_cadr[i]) begin
          cadr_ff[i] <= pwdata[ADDR_W-1:0];
        end
      end
    end
  end

  // read mux; trigger always reads zero
  logic [DATA_W-1:0] rd_val;
  always_comb begin
    rd_val = '0;
    if (paddr == OFS_CTRL) begin
      rd_val[CTL_ARM]  = armed_ff;
      rd_val[CTL_HALT] = halt_sel_ff;
      rd_val[CTL_BRK]  = brk_en_ff;
      rd_val[CTL_EEV]  = ext_en_ff;
    end
    if (sel_seq) begin
      rd_val[SEQ_M1 +: 3] = mask1_ff;
      rd_val[SEQ_M2 +: 3] = mask2_ff;
      rd_val[SEQ_MD +: 2] = mode_ff;
    end
    if (paddr == OFS_STAT) begin
      rd_val[ST_STATE +: 2] = state_ff;
      rd_val[ST_EEVF]       = eevf_ff;
      rd_val[ST_TRIGF]      = trigf_ff;
      rd_val[ST_HITF +: 3]  = hitf_ff;
    end
    for (int i = 0; i < NCMP; i++) begin
      if (sel_cctl[i]) begin
        rd_val[3:0] = cctl_ff[i];
      end
      if (sel_cadr[i]) begin
        rd_val[ADDR_W-1:0] = cadr_ff[i];
      end
    end
    if (sel_adata) begin
      rd_val = adata_ff;
    end
    if (sel_amask) begin
      rd_val = amask_ff;
    end
  end

  // one wait-free access phase: pready rises in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= WORD_RST;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      if (setup_rd) begin
        prdata_ff <= rd_val;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_armed_force_trigger;
    armed_ff && force_trigger_wr;
  endsequence
  sequence s_halt_bp;
    fire && brk_en_ff && halt_sel_ff;
  endsequence

  property p_force_trigger_fire;
    s_armed_force_trigger |=> !armed_ff && state_ff == SQ_IDLE;
  endproperty
  a_force_trigger_fire: assert property (p_force_trigger_fire)
    else $error("trigger write did not end the sequence");

  property p_hw_wins;
    fire && ctl_wr && pwdata[CTL_ARM] |=> !armed_ff;
  endproperty
  a_hw_wins: assert property (p_hw_wins)
    else $error("software write beat hardware disarm");

  property p_halt_bp;
    s_halt_bp |=> halt_req_ff && !trap_req_ff;
  endproperty
  a_halt_bp: assert property (p_halt_bp)
    else $error("halt breakpoint missing");

  property p_trap_bp;
    fire && brk_en_ff && !halt_sel_ff |=> trap_req_ff ##1 !trap_req_ff;
  endproperty
  a_trap_bp: assert property (p_trap_bp)
    else $error("soft trap request wrong");

  property p_lock;
    armed_ff && wr && sel_adata |=> $stable(adata_ff);
  endproperty
  a_lock: assert property (p_lock)
    else $error("config changed while armed");

  property p_force_trigger_zero;
    setup_rd && paddr == OFS_CTRL |=> !prdata_ff[CTL_FORCE_TRIGGER];
  endproperty
  a_force_trigger_zero: assert property (p_force_trigger_zero)
    else $error("trigger bit read as one");

  property p_stop_gate;
    stop_mode |-> !ext_adv;
  endproperty
  a_stop_gate: assert property (p_stop_gate)
    else $error("external event seen in stop mode");

  property p_halt_cmd_arm;
    halt_cmd && armed_ff && !fire && !ctl_wr |=> armed_ff && halt_req_ff;
  endproperty
  a_halt_cmd_arm: assert property (p_halt_cmd_arm)
    else $error("halt command disturbed arm");

  property p_ext_fall;
    !stop_mode [*4] ##0 ext_fall |-> $past(ext_event_input, 2) == 1'b0;
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("event without falling input");
endmodule : bpmon_top
`default_nettype wire

// *** tb/bpmon_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module bpmon_cpu_model (
  input  wire logic                         pclk,
  output var  logic                         bus_valid,
  output var  logic                         bus_rd,
  output var  logic                         bus_inst,
  output var  logic [bpmon_pkg::ADDR_W-1:0] bus_addr,
  output var  logic [bpmon_pkg::DATA_W-1:0] bus_data,
  output var  logic                         halt_cmd
);
  import bpmon_pkg::*;
  initial begin
    bus_valid = 1'b0;
    bus_rd    = 1'b0;
    bus_inst  = 1'b0;
    bus_addr  = 24'h000000;
    bus_data  = 32'h0000_0000;
    halt_cmd  = 1'b0;
  end
  // one bus cycle; afterwards address and data flip so stale values differ
  task automatic cyc(input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d,
                     input logic rd,
                     input logic inst);
    @(posedge pclk);
    bus_valid <= 1'b1;
    bus_addr  <= a;
    bus_data  <= d;
    bus_rd    <= rd;
    bus_inst  <= inst;
    @(posedge pclk);
    bus_valid <= 1'b0;
    bus_addr  <= ~a;
    bus_data  <= ~d;
    bus_rd    <= ~rd;
  endtask : cyc
  // controller halt command, one cycle wide
  task automatic halt_pulse();
    @(posedge pclk);
    halt_cmd <= 1'b1;
    @(posedge pclk);
    halt_cmd <= 1'b0;
  endtask : halt_pulse
endmodule : bpmon_cpu_model
`default_nettype wire

// *** tb/breakpoint_comparator_sequencer_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  end \
end
module breakpoint_comparator_sequencer_tb;
  import bpmon_pkg::*;
  logic               pclk      = 1'b0;
  logic               presetn   = 1'b0;
  logic               psel      = 1'b0;
  logic               penable   = 1'b0;
  logic               pwrite    = 1'b0;
  logic [PADDR_W-1:0] paddr     = 12'h000;
  logic [DATA_W-1:0]  pwdata    = 32'h0000_0000;
  logic               stop_mode = 1'b0;
  logic               ext_ev    = 1'b1;
  logic [DATA_W-1:0]  prdata_ff;
  logic               pready_ff, pslverr_ff, halt_req_ff, trap_req_ff;
  logic               armed_ff, bus_valid, bus_rd, bus_inst, halt_cmd;
  logic [ADDR_W-1:0]  bus_addr;
  logic [DATA_W-1:0]  bus_data;
  int                 err_count   = 0;
  int                 check_count = 0;

  always #12.5 pclk = ~pclk;

  bpmon_top i_bpmon_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .bus_valid(bus_valid), .bus_rd(bus_rd), .bus_inst(bus_inst),
    .bus_addr(bus_addr), .bus_data(bus_data), .halt_cmd(halt_cmd),
    .stop_mode(stop_mode), .ext_event_input(ext_ev),
    .halt_req_ff(halt_req_ff), .trap_req_ff(trap_req_ff),
    .armed_ff(armed_ff));

  bpmon_cpu_model i_bpmon_cpu_model (.pclk(pclk), .bus_valid(bus_valid),
    .bus_rd(bus_rd), .bus_inst(bus_inst), .bus_addr(bus_addr),
    .bus_data(bus_data), .halt_cmd(halt_cmd));

  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [PADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd  = prdata_ff;
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [PADDR_W-1:0] a, input logic [31:0] d);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [PADDR_W-1:0] a, input logic [31:0] x,
                     input logic xe);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK("rdata", x, r)
    `CHK("slverr", xe, e)
  endtask : rdc

  // outputs in the cycle after the sampling edge
  task automatic req(input logic h, input logic t, input logic ar);
    #1;
    `CHK("halt", h, halt_req_ff)
    `CHK("trap", t, trap_req_ff)
    `CHK("armed", ar, armed_ff)
  endtask : req

  task automatic quiet(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      s = s | halt_req_ff | trap_req_ff;
    end
    `CHK("quiet", 1'b0, s)
  endtask : quiet

  task automatic t_reset();
    rdc(OFS_CTRL, 32'h0000_0000, 1'b0);
    rdc(OFS_CCTL, {28'h0000000, CCTL_RST}, 1'b0);
    rdc(OFS_CADR, WORD_RST, 1'b0);
    rdc(12'h100, 32'h0000_0000, 1'b1);
  endtask : t_reset

  task automatic t_cmp_a();
    wr(OFS_CADR, 32'h0012_3456);
    wr(OFS_ADATA, 32'hA5A5_0F0F);
    wr(OFS_AMASK, 32'h0000_00FF);
    wr(OFS_CCTL, 32'h0000_000D);
    wr(OFS_SEQ, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0098);
    i_bpmon_cpu_model.cyc(24'h123456, 32'hA5A5_0E0F, 1'b1, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h123456, 32'hA5A5_0FF0, 1'b0, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h123456, 32'hA5A5_0FF0, 1'b1, 1'b1);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h123457, 32'hA5A5_0FF0, 1'b1, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h123456, 32'hA5A5_0FF0, 1'b1, 1'b0);
    req(1'b1, 1'b0, 1'b0);
    @(posedge pclk);
    req(1'b0, 1'b0, 1'b0);
  endtask : t_cmp_a

  task automatic t_cmp_bd();
    wr(12'h010, 32'h0000_0003);
    wr(12'h01C, 32'h0000_ABCD);
    wr(12'h014, 32'h0000_0005);
    wr(12'h020, 32'h0000_0042);
    wr(OFS_SEQ, 32'h0000_0021);
    wr(OFS_CTRL, 32'h0000_0088);
    i_bpmon_cpu_model.cyc(24'h00ABCD, 32'h0000_0000, 1'b1, 1'b1);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h123456, 32'hA5A5_0F12, 1'b1, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h00ABCD, 32'h0000_0000, 1'b1, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h00ABCD, 32'hFFFF_FFFF, 1'b0, 1'b1);
    req(1'b0, 1'b1, 1'b0);
    wr(OFS_SEQ, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0098);
    i_bpmon_cpu_model.cyc(24'h000042, 32'h0000_0000, 1'b1, 1'b0);
    req(1'b0, 1'b0, 1'b1);
    i_bpmon_cpu_model.cyc(24'h000042, 32'h5A5A_5A5A, 1'b0, 1'b0);
    req(1'b1, 1'b0, 1'b0);
  endtask : t_cmp_bd

  task automatic t_range();
    logic [ADDR_W-1:0] ad [4];
    logic              hit;
    ad = '{24'h0000FF, 24'h000100, 24'h0001FF, 24'h000200};
    wr(OFS_CADR, 32'h0000_0100);
    wr(12'h01C, 32'h0000_01FF);
    wr(OFS_CCTL, 32'h0000_0001);
    wr(12'h010, 32'h0000_0001);
    wr(OFS_AMASK, 32'hFFFF_FFFF);
    for (int m = 1; m <= 2; m++) begin
      for (int i = 0; i < 4; i++) begin
        hit = (m == 1) ? (i == 1 || i == 2) : (i == 0 || i == 3);
        wr(OFS_SEQ, {22'h000000, m[1:0], 8'h01});
        wr(OFS_CTRL, 32'h0000_0098);
        i_bpmon_cpu_model.cyc(ad[i], 32'h0000_0000, 1'b1, 1'b0);
        req(hit, 1'b0, !hit);
        wr(OFS_CTRL, 32'h0000_0000);
      end
    end
  endtask : t_range

  task automatic t_lock();
    int n;
    wr(OFS_SEQ, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0098);
    wr(OFS_CTRL, 32'h0000_0080);
    rdc(OFS_CTRL, 32'h0000_0098, 1'b0);
    rdc(OFS_STAT, 32'h0000_0001, 1'b0);
    wr(OFS_SEQ, 32'h0000_0007);
    rdc(OFS_SEQ, 32'h0000_0000, 1'b0);
    wr(OFS_ADATA, 32'h1234_5678);
    rdc(OFS_ADATA, 32'hA5A5_0F0F, 1'b0);
    wr(OFS_CTRL, 32'h0000_00C0);
    n = 0;
    while (halt_req_ff !== 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    `CHK("force_trigger halt", 1'b1, halt_req_ff)
    rdc(OFS_CTRL, 32'h0000_0018, 1'b0);
    rdc(OFS_STAT, 32'h0000_0040, 1'b0);
  endtask : t_lock

  task automatic fall_check(input logic h);
    @(posedge pclk);
    ext_ev <= 1'b0;
    repeat (3) @(posedge pclk);
    req(1'b0, 1'b0, 1'b1);
    @(posedge pclk);
    req(h, 1'b0, !h);
  endtask : fall_check

  // pin toggles stay at least two cycles apart
  task automatic t_ext();
    wr(OFS_CTRL, 32'h0000_009A);
    fall_check(1'b1);
    wr(OFS_CTRL, 32'h0000_009A);
    @(posedge pclk);
    ext_ev <= 1'b1;
    quiet(6);
    stop_mode <= 1'b1;
    @(posedge pclk);
    ext_ev <= 1'b0;
    quiet(6);
    ext_ev <= 1'b1;
    quiet(2);
    stop_mode <= 1'b0;
    quiet(4);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0098);
    @(posedge pclk);
    ext_ev <= 1'b0;
    quiet(6);
    ext_ev <= 1'b1;
    quiet(2);
  endtask : t_ext

  task automatic t_halt();
    i_bpmon_cpu_model.halt_pulse();
    req(1'b1, 1'b0, 1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
  endtask : t_halt

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cmp_a();
    t_cmp_bd();
    t_range();
    t_lock();
    t_ext();
    t_halt();
    wrap_up();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
endmodule : breakpoint_comparator_sequencer_tb
`default_nettype wire
